// file: adcba_pkg.sv
// constants, register map and state type of the converter control block
package adcba_pkg;
    // ----------------------------------------------------------------
    // register addresses and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_ACC_CFG = 8'hb3;
    localparam logic [7:0] ADDR_TRK = 8'hb9;
    localparam logic [7:0] ADDR_RES_LO = 8'hbd;
    localparam logic [7:0] ADDR_RES_HI = 8'hbe;
    localparam logic [7:0] ADDR_PWR = 8'hdf;
    localparam logic [7:0] ACC_CFG_RST = 8'h00;
    localparam logic [7:0] TRK_RST = 8'h1e;
    localparam logic [7:0] PWR_RST = 8'h0f;
    localparam logic [15:0] RES_RST = 16'h0000;
    localparam logic [7:0] RD_NONE = 8'h00;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ACC_12B = 7;
    localparam int ACC_AE = 6;
    localparam int ACC_SJ_HI = 5;
    localparam int ACC_SJ_LO = 3;
    localparam int ACC_RPT_HI = 2;
    localparam int ACC_RPT_LO = 0;
    localparam int TRK_SS = 7;
    localparam int TRK_TK_HI = 5;
    localparam int TRK_TK_LO = 0;
    localparam int PWR_BIAS_HI = 7;
    localparam int PWR_BIAS_LO = 6;
    localparam int PWR_MXLP = 5;
    localparam int PWR_LPM = 4;
    localparam int PWR_UP_HI = 3;
    localparam int PWR_UP_LO = 0;
    // ----------------------------------------------------------------
    // timing and format constants
    // ----------------------------------------------------------------
    localparam int DLY_W = 7;
    localparam logic [DLY_W-1:0] DTRACK_SAR = 7'h04;
    localparam logic [DLY_W-1:0] PWR_MULT = 7'h08;
    localparam logic [DLY_W-1:0] TRK_BASE = 7'h40;
    localparam logic [1:0] LAST_PASS = 2'h3;
    localparam logic [2:0] SJ_LEFT = 3'h4;
    localparam logic [2:0] RPT_MAX = 3'h5;
    localparam logic [6:0] REPS_ONE = 7'h01;
    localparam logic [4:0] LJ_SHIFT_10 = 5'h06;
    localparam logic [4:0] LJ_SHIFT_12 = 5'h04;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_HF,
        ST_WAIT_SAR,
        ST_CONV
    } adcba_state_e;
endpackage

// file: adcba_dly_if.sv
// delay counter hand-off between sequencer and counters
`timescale 1ns/100ps
interface adcba_dly_if #(parameter int W = 7);
    logic tick;
    logic load;
    logic [W-1:0] value;
    logic [W-1:0] cnt;
    logic expired;
    modport ctl (output tick, output load, output value,
                 input cnt, input expired);
    modport cnt_side (input tick, input load, input value,
                      output cnt, output expired);
endinterface

// file: adcba_divider.sv
// converter clock enable: source ticks divided by divider plus one
`timescale 1ns/100ps
module adcba_divider #(
    parameter int W = 5
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic src_tick,
    input wire logic [W-1:0] div,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } adcba_div_s;
    adcba_div_s s_q, s_d;

    if (W < 1) begin : g_chk
        $error("divider width must be at least one");
    end

    // a divider value lowered below the count ends the count on the next source tick
    assign tick = src_tick && (s_q.cnt >= div);

    always_comb begin
        s_d = s_q;
        if (src_tick) begin
            s_d.cnt = tick ? '0 : W'(s_q.cnt + 1'b1);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    div_spacing_a: assert property (ce && tick && div != '0 && src_tick
        |=> !tick)
        else $error("converter clock ticks too close together");
endmodule

// file: adcba_delay.sv
// down-counter that expires after a loaded number of ticks
`timescale 1ns/100ps
module adcba_delay #(
    parameter int W = 7
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    adcba_dly_if.cnt_side dly
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } adcba_dly_s;
    adcba_dly_s s_q, s_d;

    if (W < 2) begin : g_chk
        $error("delay width must be at least two");
    end

    assign dly.cnt = s_q.cnt;
    assign dly.expired = (s_q.cnt == '0);

    always_comb begin
        s_d = s_q;
        if (dly.load) begin
            s_d.cnt = dly.value;
        end else if (dly.tick && s_q.cnt != '0) begin
            s_d.cnt = W'(s_q.cnt - 1'b1);
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    dly_count_a: assert property (ce && !dly.load && dly.tick
        && s_q.cnt != '0 |=> s_q.cnt == $past(s_q.cnt) - 1'b1)
        else $error("delay counter missed a tick");
endmodule

// file: adcba_top.sv
// converter sequencing, accumulation and result formatting
//
// Function
// - twelve-bit enable runs 12-bit mode; each conversion takes four core passes.
// - non-burst: result holds latest conversion, or running sum when accumulating.
// - shift-justify formats reads: right shift 0..3, left justify, rest reserved.
// - burst repeat code selects 1,4..64 conversions, or 1..16 in 12-bit mode.
// - burst power-up waits eight times power-up field oscillator ticks.
// - delayed track adds four converter clocks to power-up and tracking delay.
// - between burst conversions wait 64 minus track field oscillator ticks.
// - no tracking delay before the first conversion of a burst.
// - 12-bit mode samples four times, or once when single sample is set.
// - high byte reads formatted upper accumulator byte; writes load it.
// - low byte reads formatted lower accumulator byte; writes load it.
// - without burst, delayed track starts conversion four converter clocks after start signal.
// - converter clock is source clock divided by divider value plus one.
`timescale 1ns/100ps
module adcba_top #(
    parameter int DIV_W = 5,
    parameter int DATA_W = 12
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    output logic [7:0] sfr_rdata,
    input wire logic burst_mode_enable,
    input wire logic delayed_track_select,
    input wire logic [DIV_W-1:0] converter_clock_divider,
    input wire logic high_freq_oscillator,
    input wire logic start_conversion,
    input wire logic core_done,
    input wire logic [DATA_W-1:0] core_data,
    output logic core_start,
    output logic core_sample,
    output logic core_twelve_bit,
    output logic [1:0] core_bias,
    output logic core_mux_lp,
    output logic core_buf_lp,
    output logic converter_clock,
    output logic busy,
    output logic conv_complete
);
    localparam int DW = adcba_pkg::DLY_W;
    if (DATA_W < 1 || DATA_W > 12) begin : g_chk
        $error("core data width must lie between 1 and 12");
    end
    typedef struct packed {
        adcba_pkg::adcba_state_e st;
        logic [7:0] acc_cfg;
        logic [7:0] trk;
        logic [7:0] pwr;
        logic [15:0] acc;
        logic [7:0] rdata;
        logic [1:0] pass;
        logic [6:0] idx;
        logic [6:0] reps;
        logic burst;
        logic start;
        logic sample;
        logic done;
    } adcba_top_s;
    adcba_top_s s_q, s_d;

    adcba_dly_if #(.W(DW)) hf_if ();
    adcba_dly_if #(.W(DW)) sar_if ();
    // ----------------------------------------------------------------
    // field views
    // ----------------------------------------------------------------
    logic twelve, accum_en, single_smp;
    logic [2:0] sj, rpt;
    logic [5:0] tk;
    logic [3:0] pup;
    logic [15:0] fmt, sum, data16;
    logic [6:0] reps_cfg;

    assign twelve = s_q.acc_cfg[adcba_pkg::ACC_12B];
    assign accum_en = s_q.acc_cfg[adcba_pkg::ACC_AE];
    assign sj = s_q.acc_cfg[adcba_pkg::ACC_SJ_HI:adcba_pkg::ACC_SJ_LO];
    assign rpt = s_q.acc_cfg[adcba_pkg::ACC_RPT_HI:adcba_pkg::ACC_RPT_LO];
    assign single_smp = s_q.trk[adcba_pkg::TRK_SS];
    assign tk = s_q.trk[adcba_pkg::TRK_TK_HI:adcba_pkg::TRK_TK_LO];
    assign pup = s_q.pwr[adcba_pkg::PWR_UP_HI:adcba_pkg::PWR_UP_LO];
    assign data16 = 16'(core_data);
    // unsigned wrap-around; software sizes repeat count to avoid overflow
    assign sum = 16'(s_q.acc + data16);

    // ----------------------------------------------------------------
    // repeat count and read formatting
    // ----------------------------------------------------------------
    always_comb begin
        reps_cfg = adcba_pkg::REPS_ONE;
        // reserved codes fall back to a single conversion
        if (rpt <= adcba_pkg::RPT_MAX) begin
            if (twelve) begin
                if (rpt != '0) begin
                    reps_cfg = 7'(adcba_pkg::REPS_ONE << (rpt - 1'b1));
                end
            end else if (rpt != '0) begin
                reps_cfg = 7'(adcba_pkg::REPS_ONE << (rpt + 1'b1));
            end
        end
    end

    always_comb begin
        if (sj < adcba_pkg::SJ_LEFT) begin
            fmt = s_q.acc >> sj;
        end else if (sj == adcba_pkg::SJ_LEFT) begin
            fmt = s_q.acc << (twelve ? adcba_pkg::LJ_SHIFT_12
                                     : adcba_pkg::LJ_SHIFT_10);
        end else begin
            fmt = s_q.acc;
        end
    end

    // ----------------------------------------------------------------
    // converter clock and delay counters
    // ----------------------------------------------------------------
    adcba_divider #(.W(DIV_W)) u_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .ce(ce),
        .src_tick(burst_mode_enable ? high_freq_oscillator : 1'b1),
        .div(converter_clock_divider),
        .tick(converter_clock)
    );

    assign hf_if.tick = high_freq_oscillator;
    assign sar_if.tick = converter_clock;
    adcba_delay #(.W(DW)) u_hf_dly (
        .clock(clock), .sys_rst(sys_rst), .ce(ce), .dly(hf_if)
    );
    adcba_delay #(.W(DW)) u_sar_dly (
        .clock(clock), .sys_rst(sys_rst), .ce(ce), .dly(sar_if)
    );

    // ----------------------------------------------------------------
    // register access and sequencer
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.done = 1'b0;
        hf_if.load = 1'b0;
        hf_if.value = '0;
        sar_if.load = 1'b0;
        sar_if.value = '0;
        if (sfr_rd) begin
            case (sfr_addr)
                adcba_pkg::ADDR_ACC_CFG: s_d.rdata = s_q.acc_cfg;
                adcba_pkg::ADDR_TRK: s_d.rdata = s_q.trk;
                adcba_pkg::ADDR_PWR: s_d.rdata = s_q.pwr;
                adcba_pkg::ADDR_RES_HI: s_d.rdata = fmt[15:8];
                adcba_pkg::ADDR_RES_LO: s_d.rdata = fmt[7:0];
                default: s_d.rdata = adcba_pkg::RD_NONE;
            endcase
        end
        if (sfr_wr) begin
            case (sfr_addr)
                adcba_pkg::ADDR_ACC_CFG: s_d.acc_cfg = sfr_wdata;
                adcba_pkg::ADDR_TRK: s_d.trk = sfr_wdata;
                adcba_pkg::ADDR_PWR: s_d.pwr = sfr_wdata;
                adcba_pkg::ADDR_RES_HI: s_d.acc[15:8] = sfr_wdata;
                adcba_pkg::ADDR_RES_LO: s_d.acc[7:0] = sfr_wdata;
                default: ;
            endcase
        end
        case (s_q.st)
            adcba_pkg::ST_IDLE: begin
                // a start during a sequence is ignored
                if (start_conversion) begin
                    s_d.burst = burst_mode_enable;
                    s_d.reps = burst_mode_enable ? reps_cfg
                                                 : adcba_pkg::REPS_ONE;
                    s_d.idx = '0;
                    if (burst_mode_enable) begin
                        // power-up covers first tracking; no track delay
                        hf_if.load = 1'b1;
                        hf_if.value = DW'(pup * adcba_pkg::PWR_MULT);
                        s_d.st = adcba_pkg::ST_WAIT_HF;
                    end else if (delayed_track_select) begin
                        sar_if.load = 1'b1;
                        sar_if.value = adcba_pkg::DTRACK_SAR;
                        s_d.st = adcba_pkg::ST_WAIT_SAR;
                    end else begin
                        s_d.st = adcba_pkg::ST_CONV;
                        s_d.start = 1'b1;
                        s_d.sample = 1'b1;
                        s_d.pass = '0;
                    end
                end
            end
            adcba_pkg::ST_WAIT_HF: begin
                if (hf_if.expired) begin
                    if (delayed_track_select) begin
                        sar_if.load = 1'b1;
                        sar_if.value = adcba_pkg::DTRACK_SAR;
                        s_d.st = adcba_pkg::ST_WAIT_SAR;
                    end else begin
                        s_d.st = adcba_pkg::ST_CONV;
                        s_d.start = 1'b1;
                        s_d.sample = 1'b1;
                        s_d.pass = '0;
                    end
                end
            end
            adcba_pkg::ST_WAIT_SAR: begin
                if (sar_if.expired) begin
                    s_d.st = adcba_pkg::ST_CONV;
                    s_d.start = 1'b1;
                    s_d.sample = 1'b1;
                    s_d.pass = '0;
                end
            end
            adcba_pkg::ST_CONV: begin
                if (core_done) begin
                    if (twelve && s_q.pass != adcba_pkg::LAST_PASS) begin
                        // the four passes cost 12-bit mode its throughput
                        s_d.pass = 2'(s_q.pass + 1'b1);
                        s_d.start = 1'b1;
                        s_d.sample = !single_smp;
                    end else begin
                        // hardware result overrides a same-cycle byte write
                        if (s_q.burst) begin
                            s_d.acc = (s_q.idx == '0) ? data16 : sum;
                        end else begin
                            s_d.acc = accum_en ? sum : data16;
                        end
                        s_d.idx = 7'(s_q.idx + 1'b1);
                        if (s_q.burst && s_d.idx < s_q.reps) begin
                            hf_if.load = 1'b1;
                            hf_if.value = DW'(adcba_pkg::TRK_BASE - tk);
                            s_d.st = adcba_pkg::ST_WAIT_HF;
                        end else begin
                            s_d.done = 1'b1;
                            s_d.st = adcba_pkg::ST_IDLE;
                        end
                    end
                end
            end
            default: s_d.st = adcba_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.st <= adcba_pkg::ST_IDLE;
            s_q.acc_cfg <= adcba_pkg::ACC_CFG_RST;
            s_q.trk <= adcba_pkg::TRK_RST;
            s_q.pwr <= adcba_pkg::PWR_RST;
            s_q.acc <= adcba_pkg::RES_RST;
            s_q.reps <= adcba_pkg::REPS_ONE;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata = s_q.rdata;
    assign core_start = s_q.start;
    assign core_sample = s_q.sample;
    assign core_twelve_bit = twelve;
    assign core_bias = s_q.pwr[adcba_pkg::PWR_BIAS_HI:adcba_pkg::PWR_BIAS_LO];
    assign core_mux_lp = s_q.pwr[adcba_pkg::PWR_MXLP];
    assign core_buf_lp = s_q.pwr[adcba_pkg::PWR_LPM];
    assign busy = (s_q.st != adcba_pkg::ST_IDLE);
    assign conv_complete = s_q.done;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic conv_end;
    assign conv_end = ce && s_q.st == adcba_pkg::ST_CONV && core_done
        && !(twelve && s_q.pass != adcba_pkg::LAST_PASS);

    twelve_pass_a: assert property (ce && s_q.st == adcba_pkg::ST_CONV
        && core_done && twelve && s_q.pass != adcba_pkg::LAST_PASS
        |=> core_start && !conv_complete)
        else $error("12-bit pass did not restart the core");
    accum_sum_a: assert property (conv_end && !s_q.burst && accum_en
        |=> s_q.acc == 16'($past(s_q.acc) + $past(data16)))
        else $error("accumulate did not add the result");
    latest_only_a: assert property (conv_end && !s_q.burst && !accum_en
        |=> s_q.acc == $past(data16))
        else $error("latest result not stored");
    shift_read_a: assert property (ce && sfr_rd && sj == 3'h1
        && sfr_addr == adcba_pkg::ADDR_RES_LO
        |=> sfr_rdata == $past(s_q.acc[8:1]))
        else $error("shifted low byte read wrong");
    powerup_load_a: assert property (ce && s_q.st == adcba_pkg::ST_IDLE
        && start_conversion && burst_mode_enable
        |=> s_q.st == adcba_pkg::ST_WAIT_HF
        && hf_if.cnt == DW'(8 * $past(pup)))
        else $error("power-up delay not loaded");
    track_load_a: assert property (conv_end && s_q.burst
        && 7'(s_q.idx + 1'b1) < s_q.reps
        |=> hf_if.cnt == DW'(64 - $past(tk)))
        else $error("track delay not loaded");
    first_conv_a: assert property (ce && s_q.st == adcba_pkg::ST_WAIT_HF
        && s_q.idx == '0 && hf_if.expired && !delayed_track_select
        |=> core_start)
        else $error("first burst conversion was delayed");
    dtrack_a: assert property (ce && s_q.st == adcba_pkg::ST_IDLE
        && start_conversion && !burst_mode_enable && delayed_track_select
        |=> s_q.st == adcba_pkg::ST_WAIT_SAR && sar_if.cnt == 7'h04)
        else $error("delayed track not applied");
    single_smp_a: assert property (core_start && twelve && single_smp
        && s_q.pass != '0 |-> !core_sample)
        else $error("single sample mode re-sampled");
    burst_count_a: assert property (conv_complete && s_q.burst
        |-> s_q.idx == s_q.reps)
        else $error("burst ended at wrong repeat count");
    hi_write_a: assert property (ce && sfr_wr && !conv_end
        && sfr_addr == adcba_pkg::ADDR_RES_HI
        |=> s_q.acc[15:8] == $past(sfr_wdata))
        else $error("high byte write lost");

    burst_done_c: cover property (conv_complete && s_q.burst
        && s_q.reps > 7'h01);
    twelve_done_c: cover property (conv_complete && twelve);
    dtrack_c: cover property (s_q.st == adcba_pkg::ST_WAIT_SAR
        && sar_if.expired);
endmodule

// file: adcba_core_model.sv
// behavioural converter core answering start pulses after a fixed latency
`timescale 1ns/100ps
module adcba_core_model #(
    parameter int LAT = 3
) (
    input wire logic clock,
    input wire logic core_start,
    input wire logic [11:0] value,
    output logic core_done,
    output logic [11:0] core_data
);
    logic run = 1'b0;
    int cnt = 0;
    initial begin
        core_done = 1'b0;
        core_data = 12'h000;
    end
    always @(posedge clock) begin
        core_done <= 1'b0;
        // data is only held with the done pulse; the inverse shows otherwise
        core_data <= ~core_data;
        if (core_start) begin
            run <= 1'b1;
            cnt <= LAT;
        end else if (run && cnt == 0) begin
            run <= 1'b0;
            core_done <= 1'b1;
            core_data <= value;
        end else if (run) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// file: tb.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("[FAIL] %0t got %h expected %h", $time, g, e); \
        end \
    end
module tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic bme = 1'b0;
    logic dts = 1'b0;
    logic [4:0] div = 5'h00;
    logic hf = 1'b0;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic [11:0] cval = 12'h2bc;
    logic [7:0] rdata, r;
    logic core_done, core_start, core_sample, core_tw, cclk, busy, cplt;
    logic [11:0] core_data;
    logic [1:0] bias;
    logic mux_lp, buf_lp;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int st[$];
    int dn[$];
    int samp;
    always #20 clock = ~clock;
    // oscillator pulse every second system cycle
    always @(negedge clock) hf <= ~hf;
    adcba_top adcba_top_i (.clock(clock), .sys_rst(sys_rst), .ce(ce),
        .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr_s), .sfr_rd(rd_s),
        .sfr_rdata(rdata), .burst_mode_enable(bme),
        .delayed_track_select(dts), .converter_clock_divider(div),
        .high_freq_oscillator(hf), .start_conversion(start),
        .core_done(core_done), .core_data(core_data),
        .core_start(core_start), .core_sample(core_sample),
        .core_twelve_bit(core_tw), .core_bias(bias), .core_mux_lp(mux_lp),
        .core_buf_lp(buf_lp), .converter_clock(cclk), .busy(busy),
        .conv_complete(cplt));
    adcba_core_model #(.LAT(3)) adcba_core_model_i (.clock(clock),
        .core_start(core_start), .value(cval), .core_done(core_done),
        .core_data(core_data));
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            stop_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        @(negedge clock);
        wr_s = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        addr = a;
        rd_s = 1'b1;
        @(negedge clock);
        rd_s = 1'b0;
        r = rdata;
    endtask
    task automatic res(input logic [15:0] ex);
        rd(8'hbd);
        `CHK(r, ex[7:0])
        rd(8'hbe);
        `CHK(r, ex[15:8])
    endtask
    task automatic conv();
        st = {};
        dn = {};
        samp = 0;
        @(negedge clock);
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        for (int n = 1; n < 3000 && cplt !== 1'b1; n++) begin
            if (core_start === 1'b1) st.push_back(n);
            if (core_start === 1'b1 && core_sample === 1'b1) samp++;
            if (core_done === 1'b1) dn.push_back(n);
            @(negedge clock);
        end
        `CHK(cplt, 1'b1)
        @(negedge clock);
        `CHK(busy, 1'b0)
    endtask
    task automatic t_reset();
        logic [7:0] ad [6] = '{8'hb3, 8'hb9, 8'hdf, 8'hbd, 8'hbe, 8'hb0};
        logic [7:0] ex [6] = '{8'h00, 8'h1e, 8'h0f, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(ad[i]);
            `CHK(r, ex[i])
        end
        `CHK({bias, mux_lp, buf_lp, core_tw}, 5'h00)
    endtask
    task automatic t_regs();
        wr(8'hdf, 8'hb5);
        rd(8'hdf);
        `CHK(r, 8'hb5)
        `CHK({bias, mux_lp, buf_lp}, 4'hb)
        wr(8'hb9, 8'h9e);
        rd(8'hb9);
        `CHK(r, 8'h9e)
        // a write while the clock enable is low must leave state frozen
        ce = 1'b0;
        wr(8'hb9, 8'h1e);
        ce = 1'b1;
        rd(8'hb9);
        `CHK(r, 8'h9e)
    endtask
    task automatic t_format();
        logic [15:0] ex;
        wr(8'hb9, 8'h1e);
        conv();
        `CHK(st.size(), 1)
        `CHK(st[0] inside {[1:2]}, 1'b1)
        for (int s = 0; s < 6; s++) begin
            wr(8'hb3, 8'(s << 3));
            ex = (s == 4) ? 16'haf00 : (s < 4) ? 16'h02bc >> s : 16'h02bc;
            res(ex);
        end
    endtask
    task automatic t_accum();
        wr(8'hb3, 8'h40);
        conv();
        conv();
        // the earlier result stays in the sum until software clears it
        res(16'h0834);
        wr(8'hbd, 8'h00);
        wr(8'hbe, 8'h00);
        res(16'h0000);
        wr(8'hb3, 8'h00);
    endtask
    task automatic t_twelve();
        cval = 12'habc;
        wr(8'hb3, 8'h80);
        conv();
        `CHK(core_tw, 1'b1)
        `CHK(st.size(), 4)
        `CHK(samp, 4)
        res(16'h0abc);
        wr(8'hb9, 8'hbf);
        conv();
        `CHK(samp, 1)
        wr(8'hb9, 8'h1e);
        wr(8'hb3, 8'h00);
        cval = 12'h2bc;
    endtask
    task automatic t_delayed();
        dts = 1'b1;
        conv();
        `CHK(st[0] inside {[4:7]}, 1'b1)
        dts = 1'b0;
    endtask
    task automatic t_divider();
        int c = 0;
        div = 5'h02;
        repeat (3) @(negedge clock);
        repeat (30) begin
            @(negedge clock);
            if (cclk === 1'b1) c++;
        end
        `CHK(c, 10)
        // change the divider away from a tick so spacing stays legal
        @(negedge clock);
        div = 5'h00;
    endtask
    task automatic t_burst();
        bme = 1'b1;
        wr(8'hb3, 8'h01);
        wr(8'hdf, 8'h01);
        wr(8'hb9, 8'h3c);
        conv();
        `CHK(st.size(), 4)
        `CHK(st[0] inside {[16:20]}, 1'b1)
        `CHK((st[1] - dn[0]) inside {[8:12]}, 1'b1)
        res(16'h0af0);
        dts = 1'b1;
        conv();
        `CHK(st[0] inside {[24:28]}, 1'b1)
        dts = 1'b0;
        wr(8'hb3, 8'h81);
        conv();
        `CHK(st.size(), 4)
        bme = 1'b0;
        wr(8'hb3, 8'h00);
    endtask
    initial begin
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        t_reset();
        t_regs();
        t_format();
        t_accum();
        t_twelve();
        t_delayed();
        t_divider();
        t_burst();
        stop_test();
    end
endmodule
